/* File: include/pwd_regs.svh */
// constants for the pulse-width output port: codes, ranges, clock scaling
`ifndef PWD_REGS_SVH
`define PWD_REGS_SVH

// port-select codes for output 0
`define PWD_PORT_FINE 16'h1000
`define PWD_PORT_COARSE 16'h1100

// legal frequency words, fine mode counts 0.1 hz
`define PWD_FREQ_FINE_MIN 16'h0014
`define PWD_FREQ_FINE_MAX 16'hffff

// legal frequency words, coarse mode counts whole hertz, any word from 2 to 32000
`define PWD_FREQ_COARSE_MIN 16'h0002
`define PWD_FREQ_COARSE_MAX 16'h7d00

// duty word in 0.1 percent, full scale
`define PWD_DUTY_MIN 16'h0000
`define PWD_DUTY_MAX 16'h03e8

// control code that stops the output
`define PWD_STOP_CODE 16'h0003

// system clock and scaling of the frequency and duty words
`define PWD_CLK_HZ 50000000
`define PWD_FINE_SCALE 10
`define PWD_DUTY_FULL 1000

`endif

/* File: include/pwd_pkg.sv */
// types shared by the pulse-width output port
package pwd_pkg;

	// command sequencer, gray codes along idle -> period -> threshold -> load
	typedef enum logic [1:0] {
		PWD_IDLE = 2'b00,
		PWD_DIV_PER = 2'b01,
		PWD_DIV_THR = 2'b11,
		PWD_LOAD = 2'b10
	} pwd_state_t;

	// frequency resolution
	typedef enum logic {
		PWD_RES_COARSE = 1'b0,
		PWD_RES_FINE = 1'b1
	} pwd_res_t;

endpackage : pwd_pkg

/* File: verilog/pwd_divider.sv */
// sequential restoring divider, one quotient bit per clock
`timescale 1ns/100ps

module pwd_divider #(
	parameter int NUM_W = 48,
	parameter int DEN_W = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// request
	input wire logic start_i,
	input wire logic [NUM_W-1:0] num_i,
	input wire logic [DEN_W-1:0] den_i,
	// answer
	output logic busy_o,
	output logic done_o,
	output logic [NUM_W-1:0] quot_o
);

	localparam int CW = $clog2(NUM_W + 1);

	logic [DEN_W:0] rem_q; // partial remainder
	logic [NUM_W-1:0] quot_q; // dividend shifting out, quotient shifting in
	logic [DEN_W-1:0] den_q; // held divisor
	logic [CW-1:0] cnt_q; // bits done
	logic busy_q;
	logic done_q;
	logic [DEN_W:0] shifted; // remainder with next dividend bit
	logic fits; // divisor fits into shifted remainder

	assign shifted = {rem_q[DEN_W-1:0], quot_q[NUM_W-1]};
	assign fits = shifted >= {1'b0, den_q};

	// iteration; a new start restarts even a busy division
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			rem_q <= '0;
			quot_q <= '0;
			den_q <= '0;
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end
		else if (start_i)
		begin
			rem_q <= '0;
			quot_q <= num_i;
			den_q <= den_i;
			cnt_q <= '0;
			busy_q <= 1'b1;
			done_q <= 1'b0;
		end
		else if (busy_q)
		begin
			// subtract when the divisor fits
			rem_q <= fits ? (shifted - {1'b0, den_q}) : shifted;
			quot_q <= {quot_q[NUM_W-2:0], fits};
			cnt_q <= cnt_q + 1'b1;
			if (cnt_q == CW'(NUM_W - 1))
			begin
				busy_q <= 1'b0;
				done_q <= 1'b1;
			end
		end
		else
		begin
			done_q <= 1'b0;
		end
	end

	assign busy_o = busy_q;
	assign done_o = done_q;
	assign quot_o = quot_q;

endmodule : pwd_divider

/* File: verilog/pwd_top.sv */
// pulse-width output port: command check, period math and waveform
// Function
// - two port codes select fine or coarse
// - fine frequency word in 0.1 hz units
// - coarse frequency word 0002 to 7d00 hertz
// - duty word 0.1 percent, up to 03e8
// - duty sets fraction of period output on
// - out-of-range port, frequency or duty sets error
// - port busy with other pulse command errors
// - interrupt issue during cyclic command errors
// - clean execution clears the error flag
// - repeat while running updates duty seamlessly
// - repeat while running keeps original frequency
// - every execution acts, not edge only
// - run until stop code 0003 or program mode
// - variant without transistor output does nothing
`timescale 1ns/100ps
`include "pwd_regs.svh"

module pwd_top #(
	parameter bit HAS_TRANSISTOR_OUT = 1'b1,
	parameter int PER_W = 32
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// pulse-width command from the program executor
	input wire logic cmd_valid_i,
	input wire logic [15:0] cmd_port_i,
	input wire logic [15:0] cmd_freq_i,
	input wire logic [15:0] cmd_duty_i,
	input wire logic cmd_from_irq_i,
	// executor and pulse-unit state
	input wire logic cyclic_cmd_busy_i,
	input wire logic other_pulse_active_i,
	input wire logic program_mode_i,
	// pulse control command
	input wire logic pulse_control_command_valid_i,
	input wire logic [15:0] pulse_control_command_code_i,
	// command status
	output logic cmd_ready_o,
	output logic cmd_done_o,
	output logic instruction_error_flag_o,
	// waveform and run status
	output logic pwm_o,
	output logic pwm_active_o,
	output logic fine_mode_o
);

	localparam int NUM_W = 48;
	localparam int DEN_W = 16;

	// range check, shared by the frequency and duty tests
	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
		input logic [15:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	// sequencer state
	pwd_pkg::pwd_state_t state_q; // command sequencer
	logic ready_q; // accepting commands
	logic done_q; // one-cycle completion pulse
	logic err_q; // instruction error flag
	pwd_pkg::pwd_res_t res_q; // resolution of the running waveform
	logic [15:0] duty_q; // duty word of the latest good command
	logic div_start_q; // divider start pulse
	logic [NUM_W-1:0] div_num_q; // divider dividend
	logic [DEN_W-1:0] div_den_q; // divider divisor
	logic [PER_W-1:0] per_new_q; // freshly computed period
	logic [PER_W-1:0] thr_new_q; // freshly computed on-threshold

	// waveform state
	logic active_q; // waveform running
	logic pend_q; // new threshold waiting for the period boundary
	logic [PER_W-1:0] per_q; // period in clocks
	logic [PER_W-1:0] thr_q; // clocks per period with output on
	logic [PER_W-1:0] cnt_q; // free-running period counter
	logic pwm_q; // output flop

	// divider answer
	logic div_done;
	logic [NUM_W-1:0] div_quot;

	// operand decode
	logic port_fine;
	logic port_coarse;
	logic port_ok;
	logic freq_ok;
	logic duty_ok;
	logic conflict;
	logic irq_clash;
	logic cmd_err;
	logic accept;
	logic stop;

	// port code selects the resolution
	assign port_fine = cmd_port_i == `PWD_PORT_FINE;
	assign port_coarse = cmd_port_i == `PWD_PORT_COARSE;
	assign port_ok = port_fine || port_coarse;

	// frequency word range depends on the resolution picked
	always_comb
	begin
		if (port_fine)
			freq_ok = in_range(cmd_freq_i, `PWD_FREQ_FINE_MIN, `PWD_FREQ_FINE_MAX);
		else if (port_coarse)
			freq_ok = in_range(cmd_freq_i, `PWD_FREQ_COARSE_MIN,
				`PWD_FREQ_COARSE_MAX);
		else
			freq_ok = 1'b0;
	end

	// duty word range
	assign duty_ok = in_range(cmd_duty_i, `PWD_DUTY_MIN, `PWD_DUTY_MAX);

	// port already driven by another pulse command
	assign conflict = other_pulse_active_i;

	// interrupt-context issue over a cyclic command in progress
	assign irq_clash = cmd_from_irq_i && cyclic_cmd_busy_i;

	// any error condition
	assign cmd_err = !port_ok || !freq_ok || !duty_ok || conflict || irq_clash;

	// every presented command is an execution; a variant without the
	// transistor stage takes none and so stays quiet
	assign accept = cmd_valid_i && ready_q && !program_mode_i
		&& HAS_TRANSISTOR_OUT;

	// stop code or program mode ends the output
	assign stop = program_mode_i || (pulse_control_command_valid_i
		&& (pulse_control_command_code_i == `PWD_STOP_CODE));

	// shared divider, used for the period on a fresh start only and for the threshold on every good execution
	pwd_divider #(
		.NUM_W(NUM_W),
		.DEN_W(DEN_W)
	) i_pwd_divider (
		.clk_i(clk_i),
		.srst_i(srst_i),
		.start_i(div_start_q),
		.num_i(div_num_q),
		.den_i(div_den_q),
		.busy_o(),
		.done_o(div_done),
		.quot_o(div_quot)
	);

	// error flag: written on each accepted execution only
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
			err_q <= 1'b0;
		else if (accept)
			err_q <= cmd_err;
	end

	// operand latching
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			res_q <= pwd_pkg::PWD_RES_COARSE;
			duty_q <= '0;
		end
		else if (accept && !cmd_err)
		begin
			// duty always follows the latest good command
			duty_q <= cmd_duty_i;
			// resolution only on a fresh start; the period comes from the divider
			if (!active_q)
			begin
				res_q <= port_fine ? pwd_pkg::PWD_RES_FINE : pwd_pkg::PWD_RES_COARSE;
			end
			// running: the new frequency word is dropped here
		end
	end

	// command sequencer
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			state_q <= pwd_pkg::PWD_IDLE;
			ready_q <= 1'b1;
			done_q <= 1'b0;
			div_start_q <= 1'b0;
			div_num_q <= '0;
			div_den_q <= '0;
			per_new_q <= '0;
			thr_new_q <= '0;
		end
		else
		begin
			div_start_q <= 1'b0;
			done_q <= 1'b0;
			if (stop)
			begin
				// abandon any computation; the divider restarts on next start
				state_q <= pwd_pkg::PWD_IDLE;
				ready_q <= 1'b1;
			end
			else
			begin
				unique case (state_q)
					pwd_pkg::PWD_IDLE:
					begin
						if (accept && cmd_err)
						begin
							// rejected: flag only, output untouched
							done_q <= 1'b1;
						end
						else if (accept && !active_q)
						begin
							// fresh start: clock rate over frequency gives the period
							ready_q <= 1'b0;
							div_start_q <= 1'b1;
							div_den_q <= cmd_freq_i;
							if (port_fine)
								div_num_q <= NUM_W'(`PWD_CLK_HZ * `PWD_FINE_SCALE);
							else
								div_num_q <= NUM_W'(`PWD_CLK_HZ);
							state_q <= pwd_pkg::PWD_DIV_PER;
						end
						else if (accept)
						begin
							// running: keep the period, rescale the threshold only
							ready_q <= 1'b0;
							div_start_q <= 1'b1;
							div_num_q <= NUM_W'(per_q) * NUM_W'(cmd_duty_i);
							div_den_q <= DEN_W'(`PWD_DUTY_FULL);
							state_q <= pwd_pkg::PWD_DIV_THR;
						end
					end
					pwd_pkg::PWD_DIV_PER:
					begin
						if (div_done)
						begin
							// period known, now the on-time share of it
							per_new_q <= div_quot[PER_W-1:0];
							div_start_q <= 1'b1;
							div_num_q <= NUM_W'(div_quot[PER_W-1:0]) * NUM_W'(duty_q);
							div_den_q <= DEN_W'(`PWD_DUTY_FULL);
							state_q <= pwd_pkg::PWD_DIV_THR;
						end
					end
					pwd_pkg::PWD_DIV_THR:
					begin
						if (div_done)
						begin
							thr_new_q <= div_quot[PER_W-1:0];
							state_q <= pwd_pkg::PWD_LOAD;
						end
					end
					pwd_pkg::PWD_LOAD:
					begin
						// waveform block loads the new values this cycle if idle, else marks them pending for the period end
						state_q <= pwd_pkg::PWD_IDLE;
						ready_q <= 1'b1;
						done_q <= 1'b1;
					end
				endcase
			end
		end
	end

	// waveform: counter, threshold swap at period end, output compare
	always_ff @(posedge clk_i)
	begin
		if (srst_i)
		begin
			active_q <= 1'b0;
			pend_q <= 1'b0;
			per_q <= '0;
			thr_q <= '0;
			cnt_q <= '0;
			pwm_q <= 1'b0;
		end
		else if (stop)
		begin
			// output drops at once and stays low
			active_q <= 1'b0;
			pend_q <= 1'b0;
			cnt_q <= '0;
			pwm_q <= 1'b0;
		end
		else if (state_q == pwd_pkg::PWD_LOAD && !active_q)
		begin
			// fresh start from the top of a period
			active_q <= 1'b1;
			per_q <= per_new_q;
			thr_q <= thr_new_q;
			cnt_q <= '0;
			pwm_q <= thr_new_q != '0;
		end
		else if (active_q)
		begin
			// a duty update waits for the period end to avoid a runt pulse
			if (state_q == pwd_pkg::PWD_LOAD)
				pend_q <= 1'b1;
			if (cnt_q == per_q - 1'b1)
			begin
				cnt_q <= '0;
				if (pend_q)
				begin
					thr_q <= thr_new_q;
					pend_q <= 1'b0;
					pwm_q <= thr_new_q != '0;
				end
				else
				begin
					pwm_q <= thr_q != '0;
				end
			end
			else
			begin
				// on while the next count sits below the threshold
				cnt_q <= cnt_q + 1'b1;
				pwm_q <= (cnt_q + 1'b1) < thr_q;
			end
		end
	end

	// outputs straight from flops
	assign cmd_ready_o = ready_q;
	assign cmd_done_o = done_q;
	assign instruction_error_flag_o = err_q;
	assign pwm_o = pwm_q;
	assign pwm_active_o = active_q;
	assign fine_mode_o = res_q; // enum code 1 is the fine resolution

endmodule : pwd_top

/* File: tb/pwd_checker.sv */
// assertion checker for the pulse-width output port
`timescale 1ns/100ps
module pwd_checker (
	// clock and reset
	input logic clk_i,
	input logic srst_i,
	// command and state inputs
	input logic cmd_valid_i,
	input logic [15:0] cmd_port_i,
	input logic [15:0] cmd_freq_i,
	input logic [15:0] cmd_duty_i,
	input logic cmd_from_irq_i,
	input logic cyclic_cmd_busy_i,
	input logic other_pulse_active_i,
	input logic program_mode_i,
	input logic pulse_control_command_valid_i,
	input logic [15:0] pulse_control_command_code_i,
	// outputs watched
	input logic cmd_ready_o,
	input logic cmd_done_o,
	input logic instruction_error_flag_o,
	input logic pwm_o,
	input logic pwm_active_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);
	logic tk; // execution taken this edge
	logic fin; // fine port code
	logic crs; // coarse port code
	logic ok; // operands and state clean
	logic stp; // stop command seen
	assign tk = cmd_valid_i & cmd_ready_o & !program_mode_i;
	assign fin = cmd_port_i == 16'h1000;
	assign crs = cmd_port_i == 16'h1100;
	assign ok = ((fin & (cmd_freq_i >= 16'h0014)) | (crs & (cmd_freq_i inside {[16'h0002:16'h7d00]})))
		& (cmd_duty_i <= 16'h03e8) & !other_pulse_active_i & !(cmd_from_irq_i & cyclic_cmd_busy_i);
	assign stp = pulse_control_command_valid_i & (pulse_control_command_code_i == 16'h0003);
	property p_port; tk & !fin & !crs |=> instruction_error_flag_o & cmd_done_o; endproperty
	a_port: assert property (p_port) else $error("bad port not flagged");
	property p_duty; tk & (cmd_duty_i > 16'h03e8) |=> instruction_error_flag_o; endproperty
	a_duty: assert property (p_duty) else $error("bad duty not flagged");
	property p_oth; tk & other_pulse_active_i |=> instruction_error_flag_o; endproperty
	a_oth: assert property (p_oth) else $error("busy port not flagged");
	property p_irq; tk & cmd_from_irq_i & cyclic_cmd_busy_i |=> instruction_error_flag_o; endproperty
	a_irq: assert property (p_irq) else $error("irq clash not flagged");
	property p_clean; tk & ok |=> !instruction_error_flag_o; endproperty
	a_clean: assert property (p_clean) else $error("clean run left flag");
	// long wait, so a stop in between is allowed to cut it
	property p_fresh;
		disable iff (srst_i | stp | program_mode_i)
		tk & ok & !pwm_active_o |=> !cmd_ready_o ##[98:101] cmd_done_o & pwm_active_o;
	endproperty
	a_fresh: assert property (p_fresh) else $error("start not done in time");
	property p_upd; tk & pwm_active_o & !stp |=> pwm_active_o; endproperty
	a_upd: assert property (p_upd) else $error("repeat broke output");
	property p_stop; stp |=> !pwm_o & !pwm_active_o & cmd_ready_o; endproperty
	a_stop: assert property (p_stop) else $error("stop ignored");
	property p_prog; program_mode_i |=> !pwm_active_o & !pwm_o; endproperty
	a_prog: assert property (p_prog) else $error("program mode ignored");
	property p_off; !pwm_active_o |-> !pwm_o; endproperty
	a_off: assert property (p_off) else $error("pin on while idle");
	// main scenarios reached
	c_start: cover property (tk & ok & !pwm_active_o);
	c_bad: cover property (tk & !ok);
	c_stop: cover property (stp & pwm_active_o);
endmodule : pwd_checker
bind pwd_top pwd_checker i_pwd_checker (.*);

/* File: tb/pwd_load.sv */
// load on the waveform pin: measures period and on-time
`timescale 1ns/100ps
module pwd_load (
	// clock
	input logic clk_i,
	// waveform pin
	input logic pwm_i,
	// figures of the last whole period
	output int per_o,
	output int hi_o
);
	int cnt_q = 0; // cycles since last rise
	int hcnt_q = 0; // on cycles since last rise
	logic last_q = 1'b0; // pin one cycle ago
	// a rise closes a period; figures lag one period after a change
	always_ff @(posedge clk_i)
	begin
		last_q <= pwm_i;
		cnt_q <= cnt_q + 1;
		hcnt_q <= hcnt_q + int'(pwm_i);
		if (pwm_i & !last_q)
		begin
			per_o <= cnt_q;
			hi_o <= hcnt_q;
			cnt_q <= 1;
			hcnt_q <= 1;
		end
	end
endmodule : pwd_load

/* File: tb/tb_pwd_top.sv */
// self-checking bench for the pulse-width output port
`timescale 1ns/100ps
module tb_pwd_top;
	logic clk_i = 1'b0, srst_i = 1'b1, vld = 1'b0, irq = 1'b0, cyc = 1'b0, oth = 1'b0;
	logic pm = 1'b0, stv = 1'b0; // program mode, stop strobe
	logic [15:0] port = 16'h0, freq = 16'h0, duty = 16'h0, stc = 16'h0;
	logic rdy, done, err, pwm, act, fine;
	int per, hi, p, fail_count = 0, n_tests = 0, tick_n = 0;
	logic [31:0] rs = 32'h771f; // xorshift state
	logic [31:0] r; // one random draw
	pwd_top i_pwd_top (.clk_i(clk_i), .srst_i(srst_i), .cmd_valid_i(vld), .cmd_port_i(port),
		.cmd_freq_i(freq), .cmd_duty_i(duty), .cmd_from_irq_i(irq), .cyclic_cmd_busy_i(cyc),
		.other_pulse_active_i(oth), .program_mode_i(pm), .pulse_control_command_valid_i(stv),
		.pulse_control_command_code_i(stc), .cmd_ready_o(rdy), .cmd_done_o(done),
		.instruction_error_flag_o(err), .pwm_o(pwm), .pwm_active_o(act), .fine_mode_o(fine));
	pwd_load i_pwd_load (.clk_i(clk_i), .pwm_i(pwm), .per_o(per), .hi_o(hi));
	// 50 mhz clock
	initial forever #10 clk_i = ~clk_i;
	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction : rnd
	// expected verdict of one execution
	function automatic logic exp_err(logic [15:0] pt, f, d, logic o, i, c);
		logic okf;
		okf = (pt == 16'h1000 && f >= 16'h0014) || (pt == 16'h1100 && f >= 16'h0002 && f <= 16'h7d00);
		return !okf || d > 16'h03e8 || o || (i && c);
	endfunction : exp_err
	// expected period in cycles
	function automatic int exp_per(logic fm, logic [15:0] f);
		return (fm ? 500000000 : 50000000) / int'(f);
	endfunction : exp_per
	task automatic chk(logic [31:0] seen, exp);
		n_tests++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	// hang guard, well above the planned run
	always @(posedge clk_i)
	begin
		tick_n++;
		if (tick_n == 60000)
		begin
			fail_count++;
			finish_test();
		end
	end
	// one execution: held until taken, then wait for the answer
	task automatic cmd(logic [15:0] pt, f, d, logic o = 1'b0, i = 1'b0, c = 1'b0);
		int k;
		@(posedge clk_i);
		vld <= 1'b1;
		port <= pt;
		freq <= f;
		duty <= d;
		oth <= o;
		irq <= i;
		cyc <= c;
		k = 0;
		do @(posedge clk_i); while (!rdy && ++k < 300);
		vld <= 1'b0;
		k = 0;
		do @(posedge clk_i); while (done !== 1'b1 && ++k < 300);
		chk(done, 1'b1);
		chk(err, exp_err(pt, f, d, o, i, c));
	endtask : cmd
	// let three periods pass, then read the load
	task automatic meas(int pe, int h);
		repeat (3 * pe + 10) @(posedge clk_i);
		chk(per, pe);
		chk(hi, h);
	endtask : meas
	task automatic stop(logic [15:0] c);
		@(posedge clk_i);
		stv <= 1'b1;
		stc <= c;
		@(posedge clk_i);
		stv <= 1'b0;
		@(posedge clk_i);
	endtask : stop
	initial
	begin
		repeat (16) @(posedge clk_i);
		srst_i <= 1'b0;
		@(posedge clk_i);
		chk({rdy, err, pwm, act}, 4'b1000);
		// refused operands, each with one cause
		cmd(16'h1001, 16'h0100, 16'h0000);
		cmd(16'h1000, 16'h0013, 16'h0000);
		cmd(16'h1100, 16'h7d01, 16'h0000);
		cmd(16'h1100, 16'h0001, 16'h0000);
		cmd(16'h1100, 16'h0100, 16'h03e9);
		cmd(16'h1100, 16'h0100, 16'h0010, 1'b1);
		cmd(16'h1100, 16'h0100, 16'h0010, 1'b0, 1'b1, 1'b1);
		chk(act, 1'b0);
		// coarse start at the top word, half duty, from interrupt context
		cmd(16'h1100, 16'h7d00, 16'h01f4, 1'b0, 1'b1, 1'b0);
		chk(fine, 1'b0);
		p = exp_per(1'b0, 16'h7d00);
		meas(p, p * 500 / 1000);
		// new duty; the ignored word would give 2034-cycle periods the load would see
		cmd(16'h1100, 16'h6000, 16'h00fa);
		meas(p, p * 250 / 1000);
		stop(16'h0002);
		chk(act, 1'b1);
		stop(16'h0003);
		chk({act, pwm}, 2'b00);
		// fine start at the top word, duty one step under full
		cmd(16'h1000, 16'hffff, 16'h03e7);
		chk(fine, 1'b1);
		p = exp_per(1'b1, 16'hffff);
		meas(p, p * 999 / 1000);
		@(posedge clk_i);
		pm <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk(act, 1'b0);
		pm <= 1'b0;
		// random executions around the legal edges
		repeat (40)
		begin
			r = rnd();
			cmd(r[0] ? 16'h1000 : (r[1] ? 16'h1100 : r[31:16]), {r[6] & r[7], r[22:8]},
				{6'h00, r[31:22]}, r[2] & r[3], r[4], r[5]);
		end
		finish_test();
	end
endmodule : tb_pwd_top
